// File: verilog/ebm_pkg.sv
package ebm_pkg;

    // ****************************************
    // operating modes, pin fields msb first
    // ****************************************
    typedef enum logic [2:0] {
        EBM_SPECIAL_SC  = 3'h0,
        EBM_EMUL_NARROW = 3'h1,
        EBM_SPECIAL_TW  = 3'h2,
        EBM_EMUL_WIDE   = 3'h3,
        EBM_NORMAL_SC   = 3'h4,
        EBM_NORMAL_NAR  = 3'h5,
        EBM_PERIPHERAL  = 3'h6,
        EBM_NORMAL_WIDE = 3'h7
    } ebm_mode_e;

    // port a/b usage
    typedef enum logic [2:0] {
        EBM_AB_GPIO   = 3'h0,
        EBM_AB_NARROW = 3'h1,
        EBM_AB_ENAR   = 3'h3,
        EBM_AB_WIDE   = 3'h2,
        EBM_AB_PERIPH = 3'h6
    } ebm_ab_mode_e;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] EBM_ADR_MODE = 8'h00;
    localparam logic [7:0] EBM_ADR_PORT_E_ASSIGNMENT = 8'h04;
    localparam logic [7:0] EBM_ADR_BUS_INTERFACE_CONTROL = 8'h08;
    localparam logic [7:0] EBM_ADR_STATUS = 8'h0c;

    // mode register fields
    localparam int EBM_MODE_LSB = 5;
    localparam int EBM_INTERNAL_VISIBILITY_BIT = 3;
    // port_e_assignment fields
    localparam int EBM_NOACCE_BIT = 7;
    localparam int EBM_PIPE_STATUS_ENABLE_BIT = 5;
    localparam int EBM_BUS_CLOCK_DISABLE_BIT = 4;
    localparam int EBM_LOW_BYTE_STROBE_ENABLE_BIT = 3;
    localparam int EBM_READ_WRITE_ENABLE_BIT = 2;
    localparam logic [7:0] EBM_PORT_E_ASSIGNMENT_MASK = 8'hbc;
    localparam logic [7:0] EBM_PORT_E_ASSIGNMENT_RST_SC = 8'h10;
    localparam logic [7:0] EBM_PORT_E_ASSIGNMENT_RST_EXP = 8'h00;
    localparam logic [7:0] EBM_PORT_E_ASSIGNMENT_RST_EMUL = 8'had;
    localparam logic [7:0] EBM_PORT_E_ASSIGNMENT_EMUL_WMASK = 8'h10;
    // bus_interface_control fields
    localparam int EBM_CLOCK_STRETCH_BIT_BIT = 0;
    localparam logic EBM_CLOCK_STRETCH_BIT_RST = 1'b1;
    // status register fields
    localparam int EBM_ST_BDM_BIT = 0;
    localparam int EBM_ST_MWD_BIT = 1;
    localparam int EBM_ST_PWD_BIT = 2;
    localparam int EBM_ST_FUNC_LSB = 8;
    localparam int EBM_ST_AB_LSB = 16;

    // fixed port e masks
    localparam logic [7:0] EBM_PE_SC_LOCK = 8'h6c;
    localparam logic [7:0] EBM_PE_EMUL_FUNC = 8'hfc;
    localparam logic [7:0] EBM_PE_ALL_PULL = 8'hff;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        ebm_ab_mode_e ab_mode;
        logic ab_pull_en;
        logic [7:0] pe_func;
        logic [7:0] pe_pull_en;
        logic internal_visibility_eff;
    } ebm_pin_cfg_s;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic latch_pend;
        ebm_mode_e mode;
        logic internal_visibility;
        logic mode_wr_done;
        logic [7:0] port_e_assignment;
        logic port_e_assignment_wr_done;
        logic clock_stretch_bit;
        logic bdm_active;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] div_cnt;
        logic bus_clk;
        ebm_pin_cfg_s cfg;
    } ebm_state_s;

endpackage

// File: verilog/ebm_mode_cfg.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ebm_mode_cfg
    import ebm_pkg::*;
#(
    parameter int BUS_PHASE_CLOCK_HALF = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // mode select pins, asynchronous
    input wire logic mode_sel_bit2_i,
    input wire logic mode_sel_bit1_i,
    input wire logic mode_sel_bit0_i,
    // background debug serial commands, one-cycle pulses
    input wire logic bdm_enter_i,
    input wire logic bdm_exit_i,
    // pin configuration and status
    output ebm_pin_cfg_s pin_cfg_o,
    output logic bus_phase_clock_o,
    output logic clock_stretch_bit_o,
    output logic background_debug_o,
    output ebm_mode_e mode_o
);

    // ****************************************
    // mode decoding helpers
    // ****************************************
    function automatic logic is_single_chip(input ebm_mode_e m);
        return (m == EBM_SPECIAL_SC) || (m == EBM_NORMAL_SC);
    endfunction

    function automatic logic is_emul(input ebm_mode_e m);
        return (m == EBM_EMUL_NARROW) || (m == EBM_EMUL_WIDE);
    endfunction

    function automatic logic is_wide(input ebm_mode_e m);
        return (m == EBM_SPECIAL_TW) || (m == EBM_EMUL_WIDE) || (m == EBM_NORMAL_WIDE);
    endfunction

    function automatic logic is_special(input ebm_mode_e m);
        return ~m[2];
    endfunction

    // default port e assignment per mode
    function automatic logic [7:0] port_e_assignment_reset(input ebm_mode_e m);
        if (is_single_chip(m)) begin
            // single-chip clears pipe, strobe, read/write enables
            return EBM_PORT_E_ASSIGNMENT_RST_SC;
        end else if (is_emul(m)) begin
            return EBM_PORT_E_ASSIGNMENT_RST_EMUL;
        end else begin
            return EBM_PORT_E_ASSIGNMENT_RST_EXP;
        end
    endfunction

    // effective pin setup from mode and enables
    function automatic ebm_pin_cfg_s pin_decode(input ebm_mode_e m, input logic [7:0] port_e_assignment,
                                                input logic internal_visibility);
        ebm_pin_cfg_s c;
        c.ab_mode = EBM_AB_GPIO;
        c.ab_pull_en = 1'b0;
        c.pe_func = '0;
        c.internal_visibility_eff = 1'b0;
        // per-mode setup follows the decoded code
        unique case (m)
            EBM_SPECIAL_SC, EBM_NORMAL_SC: begin
                // no external bus, a/b inputs without pulls
                c.ab_mode = EBM_AB_GPIO;
                c.pe_func = port_e_assignment & ~EBM_PE_SC_LOCK & EBM_PORT_E_ASSIGNMENT_MASK;
                c.pe_func[EBM_NOACCE_BIT] = 1'b0;
            end
            EBM_EMUL_NARROW: begin
                // split word accesses on port a
                // pa7 and pb0 carry the mapped lines
                c.ab_mode = EBM_AB_ENAR;
                c.pe_func = EBM_PE_EMUL_FUNC;
                c.internal_visibility_eff = internal_visibility;
            end
            EBM_EMUL_WIDE: begin
                c.ab_mode = EBM_AB_WIDE;
                c.pe_func = EBM_PE_EMUL_FUNC;
                c.internal_visibility_eff = internal_visibility;
            end
            EBM_SPECIAL_TW, EBM_NORMAL_WIDE: begin
                c.ab_mode = EBM_AB_WIDE;
                // each pin follows its enable bit
                c.pe_func = port_e_assignment & EBM_PORT_E_ASSIGNMENT_MASK;
                c.pe_func[EBM_PIPE_STATUS_ENABLE_BIT - 1] = port_e_assignment[EBM_PIPE_STATUS_ENABLE_BIT];
                c.internal_visibility_eff = internal_visibility;
            end
            EBM_NORMAL_NAR: begin
                // address on a/b, data on a, no visibility
                c.ab_mode = EBM_AB_NARROW;
                c.pe_func = port_e_assignment & EBM_PORT_E_ASSIGNMENT_MASK;
                c.pe_func[EBM_PIPE_STATUS_ENABLE_BIT - 1] = port_e_assignment[EBM_PIPE_STATUS_ENABLE_BIT];
                c.pe_func[EBM_LOW_BYTE_STROBE_ENABLE_BIT] = 1'b0;
            end
            EBM_PERIPHERAL: begin
                // external master drives a, b and e
                c.ab_mode = EBM_AB_PERIPH;
            end
        endcase
        // read/write on bit 2 only when enabled, or in emulation modes
        // strobe on bit 3 only when enabled, or in emulation modes
        // bus clock on bit 4 while disable bit is clear, except in peripheral mode
        if (m != EBM_PERIPHERAL) begin
            c.pe_func[EBM_BUS_CLOCK_DISABLE_BIT] = ~port_e_assignment[EBM_BUS_CLOCK_DISABLE_BIT];
        end
        // bits 1 and 0 never take a bus function
        c.pe_func[1:0] = 2'h0;
        // pulls on every port e pin left as an input
        c.pe_pull_en = EBM_PE_ALL_PULL & ~c.pe_func;
        return c;
    endfunction

    // ****************************************
    // state
    // ****************************************
    ebm_state_s s_reg;
    ebm_state_s s_next;

    logic req;
    logic wr_take;
    logic [7:0] wbyte;
    ebm_mode_e wmode;

    // request seen this cycle, write acts at the acked edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_take = req & s_reg.ack & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign wmode = ebm_mode_e'(wbyte[EBM_MODE_LSB +: 3]);

    // next-state logic
    always_comb begin
        s_next = s_reg;
        // first stage feeds only the second
        s_next.sync1 = {mode_sel_bit2_i, mode_sel_bit1_i, mode_sel_bit0_i};
        s_next.sync2 = s_reg.sync1;
        // wishbone: ack one cycle after request, then drop
        s_next.ack = req & ~s_reg.ack;
        s_next.rdata = '0;
        unique case (wb_adr_i)
            EBM_ADR_MODE: begin
                s_next.rdata[EBM_MODE_LSB +: 3] = s_reg.mode;
                s_next.rdata[EBM_INTERNAL_VISIBILITY_BIT] = s_reg.internal_visibility;
            end
            EBM_ADR_PORT_E_ASSIGNMENT: s_next.rdata[7:0] = s_reg.port_e_assignment;
            EBM_ADR_BUS_INTERFACE_CONTROL: s_next.rdata[EBM_CLOCK_STRETCH_BIT_BIT] = s_reg.clock_stretch_bit;
            EBM_ADR_STATUS: begin
                s_next.rdata[EBM_ST_BDM_BIT] = s_reg.bdm_active;
                s_next.rdata[EBM_ST_MWD_BIT] = s_reg.mode_wr_done;
                s_next.rdata[EBM_ST_PWD_BIT] = s_reg.port_e_assignment_wr_done;
                s_next.rdata[EBM_ST_FUNC_LSB +: 8] = s_reg.cfg.pe_func;
                s_next.rdata[EBM_ST_AB_LSB +: 3] = s_reg.cfg.ab_mode;
            end
            default: s_next.rdata = '0;
        endcase

        // register writes, refused silently where protected
        if (wr_take && s_reg.mode != EBM_PERIPHERAL) begin
            unique case (wb_adr_i)
                EBM_ADR_MODE: begin
                    if (is_special(s_reg.mode)) begin
                        // special modes may rewrite the mode
                        // only a permitted write moves the mode
                        s_next.mode = wmode;
                        s_next.internal_visibility = wbyte[EBM_INTERNAL_VISIBILITY_BIT];
                    end else if (s_reg.mode == EBM_NORMAL_SC) begin
                        // one write, to a normal bus mode
                        if (!s_reg.mode_wr_done) begin
                            s_next.mode_wr_done = 1'b1;
                            s_next.internal_visibility = wbyte[EBM_INTERNAL_VISIBILITY_BIT];
                            if (wmode == EBM_NORMAL_NAR || wmode == EBM_NORMAL_WIDE) begin
                                s_next.mode = wmode;
                            end
                        end
                    end else begin
                        // other normal modes keep mode bits
                        s_next.internal_visibility = wbyte[EBM_INTERNAL_VISIBILITY_BIT];
                    end
                end
                EBM_ADR_PORT_E_ASSIGNMENT: begin
                    if (is_emul(s_reg.mode)) begin
                        // only the clock disable stays writable
                        s_next.port_e_assignment = (s_reg.port_e_assignment & ~EBM_PORT_E_ASSIGNMENT_EMUL_WMASK) |
                                      (wbyte & EBM_PORT_E_ASSIGNMENT_EMUL_WMASK);
                    end else if (s_reg.mode == EBM_NORMAL_NAR) begin
                        if (!s_reg.port_e_assignment_wr_done) begin
                            s_next.port_e_assignment = wbyte & EBM_PORT_E_ASSIGNMENT_MASK;
                            s_next.port_e_assignment_wr_done = 1'b1;
                        end
                    end else begin
                        s_next.port_e_assignment = wbyte & EBM_PORT_E_ASSIGNMENT_MASK;
                    end
                end
                EBM_ADR_BUS_INTERFACE_CONTROL: s_next.clock_stretch_bit = wbyte[EBM_CLOCK_STRETCH_BIT_BIT];
                default: s_next.clock_stretch_bit = s_reg.clock_stretch_bit;
            endcase
        end

        // background debug serial commands
        if (bdm_enter_i) begin
            s_next.bdm_active = 1'b1;
        end else if (bdm_exit_i) begin
            s_next.bdm_active = 1'b0;
        end

        // latch pins on the first cycle after release
        if (s_reg.latch_pend) begin
            s_next.latch_pend = 1'b0;
            s_next.mode = ebm_mode_e'(s_reg.sync2);
            s_next.port_e_assignment = port_e_assignment_reset(ebm_mode_e'(s_reg.sync2));
            // only the all-zero mode starts in debug
            s_next.bdm_active = (s_reg.sync2 == EBM_SPECIAL_SC);
        end

        // bit 4 clock, halted when the pin is not the clock
        if (s_reg.cfg.pe_func[EBM_BUS_CLOCK_DISABLE_BIT]) begin
            if (s_reg.div_cnt == 8'(BUS_PHASE_CLOCK_HALF - 1)) begin
                s_next.div_cnt = 8'h00;
                s_next.bus_clk = ~s_reg.bus_clk;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 8'h01;
            end
        end else begin
            s_next.div_cnt = 8'h00;
            s_next.bus_clk = 1'b0;
        end

        s_next.cfg = pin_decode(s_reg.mode, s_reg.port_e_assignment, s_reg.internal_visibility);

        // synchronous reset; synchroniser keeps sampling
        if (rst_i) begin
            s_next = '0;
            s_next.sync1 = {mode_sel_bit2_i, mode_sel_bit1_i, mode_sel_bit0_i};
            s_next.sync2 = s_reg.sync1;
            s_next.latch_pend = 1'b1;
            s_next.mode = EBM_NORMAL_SC;
            s_next.port_e_assignment = EBM_PORT_E_ASSIGNMENT_RST_SC;
            // stretch set so a slow vector fetch works
            s_next.clock_stretch_bit = EBM_CLOCK_STRETCH_BIT_RST;
            s_next.cfg = pin_decode(EBM_NORMAL_SC, EBM_PORT_E_ASSIGNMENT_RST_SC, 1'b0);
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    // outputs straight from flip-flops
    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign pin_cfg_o = s_reg.cfg;
    assign bus_phase_clock_o = s_reg.bus_clk;
    assign clock_stretch_bit_o = s_reg.clock_stretch_bit;
    assign background_debug_o = s_reg.bdm_active;
    assign mode_o = s_reg.mode;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // latched mode equals the synchronised pins
    chk_mode_latch: assert property (s_reg.latch_pend |=> s_reg.mode == $past(s_reg.sync2))
        else $error("mode not latched from pins");
    // debug active right after a special single-chip latch
    chk_bdm_start: assert property (s_reg.latch_pend && !bdm_enter_i && !bdm_exit_i |=>
        s_reg.bdm_active == ($past(s_reg.sync2) == EBM_SPECIAL_SC))
        else $error("debug start state wrong");
    chk_pe_low_in: assert property (1'b1 |-> pin_cfg_o.pe_func[1:0] == 2'h0 &&
        pin_cfg_o.pe_pull_en[1:0] == 2'h3)
        else $error("port e bits 1,0 not pulled inputs");
    chk_clock_stretch_bit_reset: assert property ($past(rst_i) |-> clock_stretch_bit_o)
        else $error("stretch bit not set after reset");
    chk_sc_locked: assert property (is_single_chip(s_reg.mode) && $stable(s_reg.mode)
        |=> (pin_cfg_o.pe_func & EBM_PE_SC_LOCK) == 8'h00)
        else $error("single-chip pin took bus function");
    chk_narrow_strobe: assert property (s_reg.mode == EBM_NORMAL_NAR && $stable(s_reg.mode)
        |=> !pin_cfg_o.pe_func[EBM_LOW_BYTE_STROBE_ENABLE_BIT] && !pin_cfg_o.internal_visibility_eff)
        else $error("narrow mode strobe or visibility on");
    chk_emul_forced: assert property (is_emul(s_reg.mode) && $stable(s_reg.mode)
        |=> pin_cfg_o.pe_func[7:2] == EBM_PE_EMUL_FUNC[7:2])
        else $error("emulation bus pins not forced");
    chk_port_e_assignment_once: assert property (s_reg.mode == EBM_NORMAL_NAR && s_reg.port_e_assignment_wr_done
        |=> $stable(s_reg.port_e_assignment))
        else $error("second port e assignment write took");
    chk_mode_hold: assert property (!s_reg.latch_pend && !wr_take |=> $stable(s_reg.mode))
        else $error("mode changed without a write");
    chk_clk_idle: assert property (!pin_cfg_o.pe_func[EBM_BUS_CLOCK_DISABLE_BIT] [*2] |=> !bus_phase_clock_o)
        else $error("bus clock runs while disabled");
    chk_ack_pulse: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not one cycle");

    cov_wide_mode: cover property (s_reg.mode == EBM_NORMAL_WIDE && pin_cfg_o.pe_func[EBM_READ_WRITE_ENABLE_BIT]);
    cov_sc_upgrade: cover property (s_reg.mode == EBM_NORMAL_SC ##[1:20] s_reg.mode == EBM_NORMAL_NAR);
    cov_bus_clock: cover property ($rose(bus_phase_clock_o));

endmodule
`default_nettype wire

// File: dv/ebm_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side device watching the bus clock
// ****************************************
module ebm_ext_dev (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus clock pin as seen outside
    input wire logic bus_phase_clock_i,
    // measurements
    output logic [7:0] half_o,
    output logic [15:0] edges_o
);
    logic [7:0] hi_cnt;
    logic clk_d;

    // sampled with the core clock, so only whole-cycle high times are seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_cnt <= 8'h00;
            clk_d <= 1'b0;
            half_o <= 8'h00;
            edges_o <= 16'h0000;
        end else begin
            clk_d <= bus_phase_clock_i;
            if (bus_phase_clock_i) begin
                hi_cnt <= hi_cnt + 8'h01;
            end
            if (bus_phase_clock_i && !clk_d) begin
                edges_o <= edges_o + 16'h0001;
                hi_cnt <= 8'h01;
            end
            if (!bus_phase_clock_i && clk_d) begin
                half_o <= hi_cnt;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ebm_pkg::*;
    // odd divider so an off-by-one shows up
    localparam int HALF = 3;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, half;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [2:0] msel;
    logic bdm_enter_i, bdm_exit_i, bus_phase_clock_o, clock_stretch_bit_o, background_debug_o;
    logic [15:0] edges;
    ebm_pin_cfg_s pin_cfg_o;
    ebm_mode_e mode_o;
    int err_total = 0;
    int n_compared = 0;

    ebm_mode_cfg #(.BUS_PHASE_CLOCK_HALF(HALF)) u_ebm_mode_cfg (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_sel_bit2_i(msel[2]), .mode_sel_bit1_i(msel[1]),
        .mode_sel_bit0_i(msel[0]), .bdm_enter_i(bdm_enter_i), .bdm_exit_i(bdm_exit_i), .pin_cfg_o(pin_cfg_o),
        .bus_phase_clock_o(bus_phase_clock_o), .clock_stretch_bit_o(clock_stretch_bit_o),
        .background_debug_o(background_debug_o), .mode_o(mode_o));
    ebm_ext_dev u_ebm_ext_dev (.clk_i(clk_i), .rst_i(rst_i), .bus_phase_clock_i(bus_phase_clock_o),
        .half_o(half), .edges_o(edges));

    // 100 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    // classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
    endtask

    // pins stay stable across the release so the synchroniser sees them
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk_i);
        rst_i <= 1'b1;
        msel <= m;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic [31:0] exp_ab(input logic [2:0] m);
        case (m)
            3'h0, 3'h4: return 32'(EBM_AB_GPIO);
            3'h1: return 32'(EBM_AB_ENAR);
            3'h5: return 32'(EBM_AB_NARROW);
            3'h6: return 32'(EBM_AB_PERIPH);
            default: return 32'(EBM_AB_WIDE);
        endcase
    endfunction

    function automatic logic [31:0] exp_pe(input logic [2:0] m);
        case (m)
            3'h0, 3'h4: return 32'h00;
            3'h1, 3'h3: return 32'hfc;
            default: return 32'h10;
        endcase
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, bdm_enter_i, bdm_exit_i} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        msel = 3'h4;
        // every mode encoding from reset
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i));
            chk(32'(mode_o), 32'(i));
            chk(32'(background_debug_o), 32'(i == 0));
            chk(32'(clock_stretch_bit_o), 32'h1);
            chk(32'(pin_cfg_o.ab_mode), exp_ab(3'(i)));
            chk(32'(pin_cfg_o.ab_pull_en), 32'h0);
            chk({28'h0, pin_cfg_o.pe_func[1:0], pin_cfg_o.pe_pull_en[1:0]}, 32'h3);
            // no bus traffic while the peripheral encoding is selected
            if (i != 6) begin
                chk(32'(pin_cfg_o.pe_func), exp_pe(3'(i)));
                wb(1'b0, EBM_ADR_MODE, 8'h00);
                chk({29'h0, q[7:5]}, 32'(i));
                wb(1'b0, EBM_ADR_BUS_INTERFACE_CONTROL, 8'h00);
                chk({31'h0, q[0]}, 32'h1);
            end
        end
        // normal single-chip: locked pins, clock on demand, one mode write
        do_reset(3'h4);
        settle(20);
        chk(32'(edges), 32'h0);
        wb(1'b0, EBM_ADR_PORT_E_ASSIGNMENT, 8'h00);
        chk({24'h0, q[7:0]}, 32'h10);
        wb(1'b1, EBM_ADR_PORT_E_ASSIGNMENT, 8'h6c);
        settle(20);
        chk(32'(pin_cfg_o.pe_func), 32'h10);
        chk(32'(half), 32'(HALF));
        wb(1'b1, EBM_ADR_MODE, 8'he0);
        settle(3);
        chk(32'(mode_o), 32'h7);
        wb(1'b1, EBM_ADR_MODE, 8'ha0);
        settle(3);
        chk(32'(mode_o), 32'h7);
        // normal wide: control outputs by enable bits
        do_reset(3'h7);
        settle(20);
        chk(32'(half), 32'(HALF));
        wb(1'b1, EBM_ADR_PORT_E_ASSIGNMENT, 8'h0c);
        settle(3);
        chk(32'(pin_cfg_o.pe_func), 32'h1c);
        wb(1'b1, EBM_ADR_MODE, 8'h88);
        settle(3);
        chk(32'(mode_o), 32'h7);
        // normal narrow: strobe ignored, single assignment write, no visibility
        do_reset(3'h5);
        wb(1'b1, EBM_ADR_PORT_E_ASSIGNMENT, 8'h08);
        settle(3);
        chk(32'(pin_cfg_o.pe_func), 32'h10);
        wb(1'b1, EBM_ADR_PORT_E_ASSIGNMENT, 8'h04);
        wb(1'b0, EBM_ADR_PORT_E_ASSIGNMENT, 8'h00);
        chk({24'h0, q[7:0]}, 32'h08);
        wb(1'b1, EBM_ADR_MODE, 8'h08);
        settle(3);
        chk(32'(pin_cfg_o.internal_visibility_eff), 32'h0);
        // status: assignment written once, narrow a/b, clock pin only
        wb(1'b0, EBM_ADR_STATUS, 8'h00);
        chk(q, 32'h00011004);
        // emulation narrow: control pins forced, writes restricted
        do_reset(3'h1);
        wb(1'b1, EBM_ADR_PORT_E_ASSIGNMENT, 8'h00);
        wb(1'b0, EBM_ADR_PORT_E_ASSIGNMENT, 8'h00);
        chk({24'h0, q[7:0]}, 32'had);
        chk(32'(pin_cfg_o.pe_func), 32'hfc);
        // special single-chip: debug commands and open mode writes
        do_reset(3'h0);
        @(posedge clk_i);
        bdm_exit_i <= 1'b1;
        @(posedge clk_i);
        bdm_exit_i <= 1'b0;
        settle(3);
        chk(32'(background_debug_o), 32'h0);
        bdm_enter_i <= 1'b1;
        @(posedge clk_i);
        bdm_enter_i <= 1'b0;
        settle(3);
        chk(32'(background_debug_o), 32'h1);
        wb(1'b1, EBM_ADR_MODE, 8'he0);
        settle(3);
        chk(32'(mode_o), 32'h7);
        // status: debug active, wide a/b after the special write
        wb(1'b0, EBM_ADR_STATUS, 8'h00);
        chk(q, 32'h00020001);
        wb(1'b0, 8'h10, 8'h00);
        chk(q, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
